// file: core/nva_pkg.sv
package nva_pkg;

	// I/O-space offsets of the access registers
	localparam logic [5:0] NVA_OFS_CONTROL = 6'h1C;
	localparam logic [5:0] NVA_OFS_DATA    = 6'h1D;
	localparam logic [5:0] NVA_OFS_ADDR_LO = 6'h1E;
	localparam logic [5:0] NVA_OFS_ADDR_HI = 6'h1F;

	// Control register bit positions
	localparam int NVA_BIT_READ_STROBE  = 0;
	localparam int NVA_BIT_WRITE_STROBE = 1;
	localparam int NVA_BIT_MASTER_WE    = 2;
	localparam int NVA_BIT_READY_IRQ_EN = 3;

	// Reset values
	localparam logic [7:0] NVA_RST_DATA    = 8'h00;
	localparam logic [7:0] NVA_RST_ADDR_LO = 8'h00;
	localparam logic [7:0] NVA_RST_ADDR_HI = 8'h00;
	localparam logic [7:0] NVA_RST_CONTROL = 8'h00;

	// Timing
	localparam int NVA_CLOCK_HZ        = 50_000_000;
	localparam int NVA_PROG_TIME_US    = 4000;
	localparam int NVA_PROG_CYCLES     =
		NVA_PROG_TIME_US * (NVA_CLOCK_HZ / 1_000_000);
	localparam int NVA_MWE_CYCLES      = 4;
	localparam int NVA_WRITE_STALL     = 2;
	localparam int NVA_READ_STALL      = 4;

	// Control sequencer states
	typedef enum logic [1:0] {
		NVA_IDLE    = 2'b00,
		NVA_READING = 2'b01,
		NVA_WRITING = 2'b10
	} nva_state_t;

	// CPU I/O access toward the block
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} nva_io_req_t;

	// Port toward the nonvolatile array
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [9:0] addr;
		logic [7:0] wdata;
	} nva_mem_req_t;

endpackage

// file: core/nva_access_ctrl.sv
// Overview of operation
// - Bytes addressed linearly from zero to array top
// - Write strobe self-clears after programming interval
// - Accepted write stalls processor two cycles
// - Read strobe stalls processor four cycles
// - Master write enable clears four cycles later
// - Write starts only with master enable set
// - Read fetches byte, then read strobe clears
// - Ready interrupt while enabled and strobe zero
// - Control upper four bits read zero
// - Data register sources writes, receives reads
// - Control bits: irq en, master, write, read
`timescale 1ns/100ps
`default_nettype none

module nva_access_ctrl
	import nva_pkg::*;
#(
	parameter int ADDR_BITS   = 10,
	parameter int ARRAY_BYTES = 512,
	parameter int PROG_CYCLES = NVA_PROG_CYCLES
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst_n,
	// CPU I/O access
	input  wire nva_io_req_t  io_req,
	output logic [7:0]        io_rdata,
	input  wire logic         global_irq_enable,
	output logic              cpu_stall,
	output logic              ready_irq,
	// Nonvolatile array port
	output nva_mem_req_t      mem_req,
	input  wire logic [7:0]   mem_rdata
);

	// Programming counter wide enough for the whole self-timed interval
	localparam int CW = $clog2(PROG_CYCLES + 1);

	// Elaboration checks. Only bit 0 of the high address register is
	// kept, so the array can be at most 512 bytes; a larger one would
	// need a wider high field than the register map offers.
	if (ADDR_BITS != 10 || ARRAY_BYTES > 512
		|| ARRAY_BYTES < 2) begin : g_bad_geometry
		$error("nva_access_ctrl: unsupported geometry");
	end
	// A zero interval would leave the write strobe no cycle to read one
	if (PROG_CYCLES < 1) begin : g_bad_prog_time
		$error("nva_access_ctrl: PROG_CYCLES must be positive");
	end
	// The stall counter is three bits wide
	if (NVA_READ_STALL > 7 || NVA_WRITE_STALL > 7) begin : g_bad_stall
		$error("nva_access_ctrl: stall count does not fit");
	end

	// Complete state of the block, registered in one place
	typedef struct packed {
		nva_state_t   state;
		logic [7:0]   data_byte;
		logic [7:0]   addr_lo;
		logic         addr_hi;
		logic         irq_en;
		logic         master_we;
		logic [2:0]   mwe_count;
		logic         write_strobe;
		logic         read_strobe;
		logic [CW-1:0] prog_count;
		logic [2:0]   stall_count;
		nva_mem_req_t mem;
		logic [7:0]   rdata;
	} nva_regs_t;

	// Present state and the value it takes at the next edge
	nva_regs_t r;
	nva_regs_t next_r;

	// Linear address, limited to the array size. Only one high bit is
	// kept, so the top bit of the ten-bit array address stays zero.
	function automatic logic [9:0] nva_address(logic hi, logic [7:0] lo);
		logic [9:0] a;
		a = {1'b0, hi, lo};
		nva_address = a % 10'(ARRAY_BYTES);
	endfunction

	// One decoded I/O write to a given register offset
	function automatic logic reg_write_hit(nva_io_req_t q,
		logic [5:0] ofs);
		reg_write_hit = q.wr && q.addr == ofs;
	endfunction

	// Decoded requests of this cycle
	logic ctl_wr;                   // Control register written
	logic new_read;                 // Read strobe accepted from idle
	logic new_write;                // Enabled write strobe accepted

	// Register access decode and sequencing
	always_comb begin
		next_r = r;
		next_r.mem.rd = 1'b0;
		next_r.mem.wr = 1'b0;
		ctl_wr = reg_write_hit(io_req, NVA_OFS_CONTROL);
		new_read = 1'b0;
		new_write = 1'b0;

		// Plain register loads. Address and data are copied to the array
		// port when a write starts, so a later load cannot corrupt that
		// write; software still has to leave them alone until it ends.
		if (reg_write_hit(io_req, NVA_OFS_DATA))
			next_r.data_byte = io_req.wdata;
		if (reg_write_hit(io_req, NVA_OFS_ADDR_LO))
			next_r.addr_lo = io_req.wdata;
		if (reg_write_hit(io_req, NVA_OFS_ADDR_HI))
			next_r.addr_hi = io_req.wdata[0];

		// Master enable counts up and drops after four cycles, which bounds
		// the window in which a stray write strobe can start a write
		if (r.master_we) begin
			if (r.mwe_count == 3'(NVA_MWE_CYCLES - 1))
				next_r.master_we = 1'b0;
			else
				next_r.mwe_count = r.mwe_count + 3'h1;
		end

		// Stall counts down; an accepted strobe below reloads it
		if (r.stall_count != 3'h0)
			next_r.stall_count = r.stall_count - 3'h1;

		// Control write: interrupt enable follows the written bit, while
		// master enable is only set here and cleared by hardware. A second
		// set while the bit stands does not restart its count.
		if (ctl_wr) begin
			next_r.irq_en = io_req.wdata[NVA_BIT_READY_IRQ_EN];
			if (io_req.wdata[NVA_BIT_MASTER_WE] && !r.master_we) begin
				next_r.master_we = 1'b1;
				next_r.mwe_count = 3'h0;
			end
			// Strobes only take effect from idle; busy writes ignore them
			if (r.state == NVA_IDLE) begin
				if (io_req.wdata[NVA_BIT_WRITE_STROBE] && r.master_we)
					new_write = 1'b1;
				else if (io_req.wdata[NVA_BIT_READ_STROBE])
					new_read = 1'b1;
			end
		end

		// Sequencer: idle, a one-cycle read, or a self-timed write
		case (r.state)
			NVA_IDLE: begin
				// The array takes address and data with the one-cycle pulse
				if (new_write) begin
					next_r.state = NVA_WRITING;
					next_r.write_strobe = 1'b1;
					next_r.master_we = 1'b0;
					next_r.prog_count = CW'(PROG_CYCLES - 1);
					next_r.stall_count = 3'(NVA_WRITE_STALL);
					next_r.mem.wr = 1'b1;
					next_r.mem.addr = nva_address(r.addr_hi, r.addr_lo);
					next_r.mem.wdata = r.data_byte;
				end else if (new_read) begin
					next_r.state = NVA_READING;
					next_r.read_strobe = 1'b1;
					next_r.stall_count = 3'(NVA_READ_STALL);
					next_r.mem.rd = 1'b1;
					next_r.mem.addr = nva_address(r.addr_hi, r.addr_lo);
				end
			end
			NVA_READING: begin
				// Array answers within the cycle of the read request pulse
				next_r.data_byte = mem_rdata;
				next_r.read_strobe = 1'b0;
				next_r.state = NVA_IDLE;
			end
			NVA_WRITING: begin
				// Strobe reads one until the programming count runs out
				if (r.prog_count == '0) begin
					next_r.write_strobe = 1'b0;
					next_r.state = NVA_IDLE;
				end else
					next_r.prog_count = r.prog_count - CW'(1);
			end
			default: next_r.state = NVA_IDLE;
		endcase

		// Read data register; flops keep the data output glitch-free.
		// Unmapped offsets and cycles without a read return zero.
		next_r.rdata = 8'h00;
		if (io_req.rd) begin
			case (io_req.addr)
				NVA_OFS_DATA:    next_r.rdata = next_r.data_byte;
				NVA_OFS_ADDR_LO: next_r.rdata = next_r.addr_lo;
				NVA_OFS_ADDR_HI: next_r.rdata = {7'h00, next_r.addr_hi};
				NVA_OFS_CONTROL: next_r.rdata = {4'h0,
					next_r.irq_en, next_r.master_we,
					next_r.write_strobe, next_r.read_strobe};
				default:         next_r.rdata = 8'h00;
			endcase
		end
	end

	// State register. Reset is synchronous and loads constants only, so a
	// write cut by reset leaves the strobe clear and the block idle.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			r <= '0;
			r.state <= NVA_IDLE;
			r.data_byte <= NVA_RST_DATA;
			r.addr_lo <= NVA_RST_ADDR_LO;
			r.addr_hi <= NVA_RST_ADDR_HI[0];
		end else
			r <= next_r;
	end

	// Outputs. Read data comes straight from flops and stall is decoded from
	// the stall count; the ready interrupt gates irq_en and the inverted write strobe with the global enable.
	assign io_rdata = r.rdata;
	assign mem_req = r.mem;
	assign cpu_stall = r.stall_count != 3'h0;
	assign ready_irq = r.irq_en && global_irq_enable
		&& !r.write_strobe;

endmodule // nva_access_ctrl

`default_nettype wire

// file: sim/nva_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module nva_mem_model
	import nva_pkg::*;
(
	// Array port
	input  wire logic         clock,
	input  wire nva_mem_req_t mem_req,
	output logic [7:0]        mem_rdata
);
	logic [7:0] cells [512];
	// Writes land at the edge that closes the request pulse
	always_ff @(posedge clock) begin
		if (mem_req.wr)
			cells[mem_req.addr[8:0]] <= mem_req.wdata;
	end
	// Read answers within the pulse cycle; off a read the output shows
	// the inverse, so a sample taken too early or too late never passes
	assign mem_rdata = mem_req.rd ? cells[mem_req.addr[8:0]]
		: ~cells[mem_req.addr[8:0]];
endmodule // nva_mem_model
`default_nettype wire

// file: sim/nva_access_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none
module nva_access_ctrl_chk
	import nva_pkg::*;
(
	// Clock and reset
	input wire logic         clock,
	input wire logic         rst_n,
	// CPU side
	input wire nva_io_req_t  io_req,
	input wire logic [7:0]   io_rdata,
	input wire logic         global_irq_enable,
	input wire logic         cpu_stall,
	input wire logic         ready_irq,
	// Array side
	input wire nva_mem_req_t mem_req,
	input wire logic [7:0]   mem_rdata
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Stall lengths give the CPU exact wait states
	property p_ws;
		mem_req.wr |-> cpu_stall[*2] ##1 !cpu_stall;
	endproperty
	a_ws: assert property (p_ws) else $error("write stall");
	property p_rs;
		mem_req.rd |-> cpu_stall[*4] ##1 !cpu_stall;
	endproperty
	a_rs: assert property (p_rs) else $error("read stall");
	property p_rp; mem_req.rd |=> !mem_req.rd; endproperty
	a_rp: assert property (p_rp) else $error("read pulse");
	property p_wg; mem_req.wr |=> (!mem_req.wr)[*8]; endproperty
	a_wg: assert property (p_wg) else $error("write gap");
	property p_irq; ready_irq |-> global_irq_enable; endproperty
	a_irq: assert property (p_irq) else $error("irq gate");
	property p_hi;
		io_req.rd && io_req.addr == NVA_OFS_CONTROL |=> io_rdata[7:4] == 4'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("upper bits");
	property p_ie;
		io_req.rd && io_req.addr == NVA_OFS_CONTROL && ready_irq |=> io_rdata[3];
	endproperty
	a_ie: assert property (p_ie) else $error("irq enable bit");
	property p_ex; !(mem_req.rd && mem_req.wr); endproperty
	a_ex: assert property (p_ex) else $error("rd and wr");
	c_wr: cover property (mem_req.wr);
	c_rd: cover property (mem_req.rd);
	c_irq: cover property (ready_irq);
endmodule // nva_access_ctrl_chk
bind nva_access_ctrl nva_access_ctrl_chk u_chk (
	.clock(clock),
	.rst_n(rst_n),
	.io_req(io_req),
	.io_rdata(io_rdata),
	.global_irq_enable(global_irq_enable),
	.cpu_stall(cpu_stall),
	.ready_irq(ready_irq),
	.mem_req(mem_req),
	.mem_rdata(mem_rdata)
);
`default_nettype wire

// file: sim/tb_nva_access_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_nva_access_ctrl
	import nva_pkg::*;
;
	logic         clock = 1'b0;
	logic         rst_n = 1'b0;
	logic         irq_on = 1'b1;
	nva_io_req_t  io_req = '0;
	nva_mem_req_t mem_req;
	logic [7:0]   io_rdata, mem_rdata;
	logic         cpu_stall, ready_irq;
	int           num_errors = 0;
	int           total_checks = 0;
	// 50 MHz
	always #10 clock = ~clock;
	// Short programming time keeps the run brief
	localparam int PROG = 20;
	nva_access_ctrl #(.PROG_CYCLES(PROG)) dut (.clock(clock), .rst_n(rst_n),
		.io_req(io_req), .io_rdata(io_rdata), .global_irq_enable(irq_on),
		.cpu_stall(cpu_stall), .ready_irq(ready_irq), .mem_req(mem_req),
		.mem_rdata(mem_rdata));
	nva_mem_model mem (.clock(clock), .mem_req(mem_req), .mem_rdata(mem_rdata));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Idle edge between accesses avoids double drives
	task io(input logic r, input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		io_req <= '{r, !r, a, d};
		@(posedge clock);
		io_req <= '0;
	endtask
	task rd(input logic [5:0] a, input logic [7:0] exp);
		io(1'b1, a, 8'h00);
		#1 chk(io_rdata, exp);
	endtask
	task wr(input logic [5:0] a, input logic [7:0] d);
		io(1'b0, a, d);
	endtask
	// Single-bit outputs
	task flag(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask
	// Write procedure; strobe lands two edges after master enable
	task put(input logic [9:0] a, input logic [7:0] d);
		wr(NVA_OFS_ADDR_HI, {6'h00, a[9:8]});
		wr(NVA_OFS_ADDR_LO, a[7:0]);
		if (d != 8'h00) begin
			wr(NVA_OFS_DATA, d);
			wr(NVA_OFS_CONTROL, 8'h0C);
			wr(NVA_OFS_CONTROL, 8'h0A);
			#1 flag(ready_irq, 1'b0);
			flag(cpu_stall, 1'b1);
			rd(NVA_OFS_CONTROL, 8'h0A);
			flag(cpu_stall, 1'b0);
			repeat (PROG - 5) @(posedge clock);
			rd(NVA_OFS_CONTROL, 8'h0A);
			rd(NVA_OFS_CONTROL, 8'h08);
			flag(ready_irq, 1'b1);
		end
	endtask
	task get(input logic [9:0] a, input logic [7:0] exp);
		put(a, 8'h00);
		wr(NVA_OFS_CONTROL, 8'h09);
		#1 flag(cpu_stall, 1'b1);
		rd(NVA_OFS_DATA, exp);
		flag(cpu_stall, 1'b1);
		rd(NVA_OFS_CONTROL, 8'h08);
		flag(cpu_stall, 1'b0);
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 27; i < 32; i++)
			rd(i[5:0], 8'h00);
		flag(ready_irq, 1'b0);
		wr(NVA_OFS_CONTROL, 8'h02);
		rd(NVA_OFS_CONTROL, 8'h00);
		wr(NVA_OFS_CONTROL, 8'h04);
		rd(NVA_OFS_CONTROL, 8'h04);
		rd(NVA_OFS_CONTROL, 8'h00);
		wr(NVA_OFS_CONTROL, 8'h02);
		rd(NVA_OFS_CONTROL, 8'h00);
		$display("refusals done");
		put(10'h123, 8'hA5);
		put(10'h023, 8'h5A);
		get(10'h123, 8'hA5);
		get(10'h023, 8'h5A);
		// Global enable gates the ready interrupt
		flag(ready_irq, 1'b1);
		@(posedge clock);
		irq_on <= 1'b0;
		@(posedge clock);
		#1 flag(ready_irq, 1'b0);
		$display("write and read done");
		print_verdict();
	end
	// Watchdog on a hang
	initial begin
		repeat (2000) @(posedge clock);
		num_errors++;
		print_verdict();
	end
endmodule // tb_nva_access_ctrl
`default_nettype wire
